/* rtl/rss_pkg.sv */
// Shared constants, types and helper functions for the reset strap sampler.
`default_nettype none

package rss_pkg;

  // Strap pad positions on the shared pad vector.
  localparam int PAD_N = 8;
  localparam int PAD_ADDR_LSB = 0;
  localparam int PAD_MODE_LO = 5;
  localparam int PAD_MODE_HI = 6;
  localparam int PAD_AUTONEG_ENABLE_STRAP = 7;

  // Weak internal pull direction per pad: one is a pull-up, zero a pull-down.
  localparam logic [7:0] PAD_PULL_UP = 8'he1;

  // Register byte offsets on the AXI4-Lite bus.
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BMCR = 8'h04;
  localparam logic [7:0] OFS_ANAR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  // Field positions.
  localparam int BMCR_DUPLEX_BIT = 8;
  localparam int BMCR_AN_BIT = 12;
  localparam int BMCR_SPEED_BIT = 13;
  localparam int ANAR_ADV_LSB = 5;
  localparam int STAT_ISOLATE_BIT = 0;
  localparam int STAT_LOADED_BIT = 1;
  localparam int STAT_STRAP_LSB = 8;

  // Reset values, matching the pads left to their internal pulls.
  localparam logic [4:0] CTRL_ADDR_RST = 5'h01;
  localparam logic BMCR_AN_RST = 1'b1;
  localparam logic BMCR_SPEED_RST = 1'b1;
  localparam logic BMCR_DUPLEX_RST = 1'b1;
  localparam logic [3:0] ANAR_ADV_RST = 4'hf;
  localparam logic [4:0] ISOLATE_ADDR = 5'h00;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Captured strap levels.
  typedef struct packed {
    logic autoneg_enable_strap;
    logic [1:0] mode;
    logic [4:0] addr;
  } rss_strap_t;

  // One register write handed from the bus slave to the register file.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rss_wr_t;

  typedef enum logic [1:0] {
    LD_RESET = 2'h0,
    LD_LOAD = 2'h1,
    LD_RUN = 2'h3
  } rss_ld_state_t;

  // Advertised abilities {100 full, 100 half, 10 full, 10 half} for a mode strap code.
  function automatic logic [3:0] rss_adv_from_mode(input logic [1:0] mode);
    logic [3:0] adv;
    case (mode)
      2'h0: adv = 4'h3;
      2'h1: adv = 4'hc;
      2'h2: adv = 4'h5;
      default: adv = 4'hf;
    endcase
    return adv;
  endfunction

  // Decodes the pad vector into strap fields.
  function automatic rss_strap_t rss_decode_pads(input logic [7:0] pads);
    rss_strap_t s;
    s.addr = pads[PAD_ADDR_LSB +: 5];
    s.mode = {pads[PAD_MODE_HI], pads[PAD_MODE_LO]};
    s.autoneg_enable_strap = pads[PAD_AUTONEG_ENABLE_STRAP];
    return s;
  endfunction

  // Merges the low 16 bits of a write under byte strobes.
  function automatic logic [15:0] rss_merge16(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

endpackage

`default_nettype wire

/* rtl/rss_strap_capture.sv */
// Strap pad sampler that follows the pads while reset is held and freezes at release.
`timescale 1ns/1ns
`default_nettype none

module rss_strap_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pads and captured value
  input wire logic [7:0] pad_i,
  output rss_pkg::rss_strap_t cap_o
);
  import rss_pkg::*;

  rss_strap_t cap_reg;
  rss_strap_t cap_next;

  // The value seen at the last edge under reset is the one kept.
  always_comb begin
    cap_next = cap_reg;
    if (!rst_n_i) begin
      cap_next = rss_decode_pads(pad_i);
    end
  end

  always_ff @(posedge clk_i) begin
    cap_reg <= cap_next;
  end

  assign cap_o = cap_reg;

  a_cap_at_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> cap_o == rss_decode_pads($past(pad_i)))
    else $error("strap capture does not hold the last value sampled under reset");

  a_cap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && $past(rst_n_i)) |-> $stable(cap_o))
    else $error("strap capture changed after reset release");

endmodule

`default_nettype wire

/* rtl/rss_axil_slave.sv */
// AXI4-Lite slave that hands single writes and reads to the register file.
`timescale 1ns/1ns
`default_nettype none

module rss_axil_slave (
  // Clock, reset and bus enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  // Write address and data channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output rss_pkg::rss_wr_t wr_o,
  input wire logic wr_err_i,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  import rss_pkg::*;

  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_wr;

  assign s_axi_awready = enable_i && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = enable_i && !w_held_reg && !bvalid_reg;
  assign s_axi_arready = enable_i && !rvalid_reg;
  assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_addr_o = s_axi_araddr;

  always_comb begin
    wr_o.en = do_wr;
    wr_o.addr = aw_addr_reg;
    wr_o.data = w_data_reg;
    wr_o.strb = w_strb_reg;
  end

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end else if (do_wr) begin
      aw_held_next = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end else if (do_wr) begin
      w_held_next = 1'b0;
    end
    if (do_wr) begin
      bvalid_next = 1'b1;
      bresp_next = wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_data_i;
      rresp_next = rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

/* rtl/rss_top.sv */
// Reset strap sampler: captures strap pads at reset and holds the configuration registers.
`timescale 1ns/1ns
`default_nettype none

module rss_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Strap pads, four signals each
  input wire logic [7:0] pad_i,
  output logic [7:0] pad_o,
  output logic [7:0] pad_oe_o,
  output logic [7:0] pad_pull_up_o,
  // Functional drivers that own the pads after reset
  input wire logic col_i,
  input wire logic [3:0] rxd_i,
  input wire logic link_led_i,
  input wire logic speed_led_i,
  input wire logic activity_collision_led_i,
  // Configuration to the rest of the transceiver
  output logic [4:0] phy_addr_o,
  output logic isolate_o,
  output logic an_enable_o,
  output logic speed100_o,
  output logic full_duplex_o,
  output logic [3:0] adv_o,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rss_pkg::*;

  rss_strap_t cap;
  rss_wr_t wr;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  rss_ld_state_t state_reg, state_next;
  logic [4:0] addr_reg, addr_next;
  logic isolate_reg, isolate_next;
  logic an_reg, an_next;
  logic speed_reg, speed_next;
  logic duplex_reg, duplex_next;
  logic [3:0] adv_reg, adv_next;
  logic [7:0] pad_o_reg, pad_o_next;
  logic [7:0] pad_oe_reg, pad_oe_next;
  logic [15:0] merged;
  logic bus_en;

  rss_strap_capture u_capture (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pad_i(pad_i),
    .cap_o(cap)
  );

  // The bus stays closed until the straps are in the registers, so a write can never race the load.
  assign bus_en = (state_reg == LD_RUN);

  rss_axil_slave u_bus (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(bus_en),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_o(wr),
    .wr_err_i(wr_err),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // The pulls are fixed silicon; the pad model resolves a released pad with no strap resistor to this level.
  assign pad_pull_up_o = PAD_PULL_UP;

  // Register read view.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case ({rd_addr[7:2], 2'b00})
      OFS_CTRL: rd_data[4:0] = addr_reg;
      OFS_BMCR: begin
        rd_data[BMCR_AN_BIT] = an_reg;
        rd_data[BMCR_SPEED_BIT] = speed_reg;
        rd_data[BMCR_DUPLEX_BIT] = duplex_reg;
      end
      OFS_ANAR: rd_data[ANAR_ADV_LSB +: 4] = adv_reg;
      OFS_STAT: begin
        rd_data[STAT_ISOLATE_BIT] = isolate_reg;
        rd_data[STAT_LOADED_BIT] = bus_en;
        rd_data[STAT_STRAP_LSB +: 8] = cap;
      end
      default: rd_err = 1'b1;
    endcase
  end

  // Writes to the status word are accepted and ignored; only unmapped words are refused.
  always_comb begin
    case ({wr.addr[7:2], 2'b00})
      OFS_CTRL, OFS_BMCR, OFS_ANAR, OFS_STAT: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // Loader sequence and register file.
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    isolate_next = isolate_reg;
    an_next = an_reg;
    speed_next = speed_reg;
    duplex_next = duplex_reg;
    adv_next = adv_reg;
    merged = 16'h0000;
    case (state_reg)
      LD_RESET: state_next = LD_LOAD;
      LD_LOAD: begin
        addr_next = cap.addr;
        isolate_next = (cap.addr == ISOLATE_ADDR);
        an_next = cap.autoneg_enable_strap;
        speed_next = cap.mode[1];
        duplex_next = cap.mode[0];
        adv_next = rss_adv_from_mode(cap.mode);
        state_next = LD_RUN;
      end
      LD_RUN: begin
        if (wr.en) begin
          case ({wr.addr[7:2], 2'b00})
            OFS_CTRL: begin
              merged = rss_merge16({11'h000, addr_reg}, wr.data, wr.strb);
              // The isolate flag is not touched here, whatever address is written.
              addr_next = merged[4:0];
            end
            OFS_BMCR: begin
              merged = rss_merge16({2'h0, speed_reg, an_reg, 3'h0, duplex_reg, 8'h00}, wr.data, wr.strb);
              an_next = merged[BMCR_AN_BIT];
              speed_next = merged[BMCR_SPEED_BIT];
              duplex_next = merged[BMCR_DUPLEX_BIT];
            end
            OFS_ANAR: begin
              merged = rss_merge16({7'h00, adv_reg, 5'h00}, wr.data, wr.strb);
              adv_next = merged[ANAR_ADV_LSB +: 4];
            end
            default: merged = 16'h0000;
          endcase
        end
      end
      default: state_next = LD_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= LD_RESET;
      addr_reg <= CTRL_ADDR_RST;
      isolate_reg <= 1'b0;
      an_reg <= BMCR_AN_RST;
      speed_reg <= BMCR_SPEED_RST;
      duplex_reg <= BMCR_DUPLEX_RST;
      adv_reg <= ANAR_ADV_RST;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      isolate_reg <= isolate_next;
      an_reg <= an_next;
      speed_reg <= speed_next;
      duplex_reg <= duplex_next;
      adv_reg <= adv_next;
    end
  end

  // Pad drivers: released under reset and during the load, functional afterwards.
  always_comb begin
    pad_o_next = {activity_collision_led_i, speed_led_i, link_led_i, rxd_i, col_i};
    pad_oe_next = (state_reg == LD_RUN) ? 8'hff : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pad_o_reg <= 8'h00;
      pad_oe_reg <= 8'h00;
    end else begin
      pad_o_reg <= pad_o_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  assign pad_o = pad_o_reg;
  assign pad_oe_o = pad_oe_reg;
  assign phy_addr_o = addr_reg;
  assign isolate_o = isolate_reg;
  assign an_enable_o = an_reg;
  assign speed100_o = speed_reg;
  assign full_duplex_o = duplex_reg;
  assign adv_o = adv_reg;

  a_pads_released: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> pad_oe_o == 8'h00 ##1 pad_oe_o == 8'h00)
    else $error("strap pads driven before the straps were loaded");

  a_addr_loaded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD) |=> phy_addr_o == $past(cap.addr))
    else $error("management address not loaded from the straps");

  a_isolate_strap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD) |=> isolate_o == ($past(cap.addr) == 5'h00))
    else $error("isolate state does not follow the strapped address");

  a_isolate_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_RUN && wr.en) |=> $stable(isolate_o))
    else $error("register write changed the isolate state");

  a_pads_returned: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD) |=> ##1 pad_oe_o == 8'hff)
    else $error("strap pads not returned to their functional roles");

  a_forced_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD && !cap.autoneg_enable_strap) |=>
      (!an_enable_o && speed100_o == $past(cap.mode[1]) && full_duplex_o == $past(cap.mode[0])))
    else $error("forced mode does not match the mode straps");

  a_adv_loaded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD) |=> (adv_o == rss_adv_from_mode($past(cap.mode)) && an_enable_o == $past(cap.autoneg_enable_strap)))
    else $error("advertisement or autoneg enable not loaded from the straps");

  a_reload_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (state_reg == LD_RESET && phy_addr_o == CTRL_ADDR_RST) ##1 state_reg == LD_LOAD)
    else $error("reset release did not restart the strap load");

  a_autoneg_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_LOAD && cap.autoneg_enable_strap) |=> (an_enable_o && bus_en))
    else $error("autoneg strap high did not enable auto-negotiation");

  a_pads_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_RUN) |=> (pad_o[0] == $past(col_i) && pad_o[4:1] == $past(rxd_i) &&
      pad_o[5] == $past(link_led_i) && pad_o[6] == $past(speed_led_i) &&
      pad_o[7] == $past(activity_collision_led_i)))
    else $error("functional outputs do not reach the shared pads");

  a_isolate_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg != LD_LOAD) |=> $stable(isolate_o))
    else $error("isolate state changed outside the strap load");

  // A software address write must land, yet leave the isolate decision alone.
  a_ctrl_written: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == LD_RUN && wr.en && wr.strb[0] && wr.addr[7:2] == OFS_CTRL[7:2]) |=>
      (phy_addr_o == $past(wr.data[4:0]) && $stable(isolate_o)))
    else $error("address write not taken or isolate state disturbed");

  a_bus_closed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg != LD_RUN) |-> (!s_axi_awready && !s_axi_wready && !s_axi_arready))
    else $error("register bus open before the strap load finished");

  a_pads_idle: assert property (@(posedge clk_i)
    !rst_n_i |=> pad_oe_o == 8'h00)
    else $error("strap pads driven while reset is held");

endmodule

`default_nettype wire

/* testbench/rss_board_model.sv */
// Board model of the strap pads: device driver, optional strap resistor, else the weak internal pull.
`timescale 1ns/1ns
`default_nettype none

module rss_board_model (
  // Device side of each pad
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic [7:0] dev_pull_up_i,
  // Board strap resistors
  input wire logic [7:0] res_en_i,
  input wire logic [7:0] res_val_i,
  // Resolved pad levels
  output logic [7:0] pad_o
);
  // A strong driver wins over the resistor, which in turn wins over the weak pull.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe_i[i]) begin
        pad_o[i] = dev_out_i[i];
      end else if (res_en_i[i]) begin
        pad_o[i] = res_val_i[i];
      end else begin
        pad_o[i] = dev_pull_up_i[i];
      end
    end
  end
endmodule

`default_nettype wire

/* testbench/reset_strap_sampler_tb.sv */
// Self-checking bench for the reset strap sampler.
`timescale 1ns/1ns
`default_nettype none

module reset_strap_sampler_tb;
  import rss_pkg::*;
  logic clk_i = 0, rst_n_i = 0;
  logic [7:0] pad_i, pad_o, pad_oe_o, pad_pull_up_o, res_en = 0, res_val = 0;
  logic col_i = 0, link_led_i = 0, speed_led_i = 0, activity_collision_led_i = 0;
  logic [3:0] rxd_i = 0, adv_o, s_axi_wstrb = 0;
  logic [4:0] phy_addr_o;
  logic isolate_o, an_enable_o, speed100_o, full_duplex_o;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_fail = 0, compares = 0, cycles = 0;
  logic [7:0] st;
  logic [4:0] fn;

  always #50 clk_i = ~clk_i;

  rss_board_model i_rss_board_model (.dev_out_i(pad_o), .dev_oe_i(pad_oe_o), .dev_pull_up_i(pad_pull_up_o),
    .res_en_i(res_en), .res_val_i(res_val), .pad_o(pad_i));

  rss_top i_rss_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
    .pad_pull_up_o(pad_pull_up_o), .col_i(col_i), .rxd_i(rxd_i), .link_led_i(link_led_i),
    .speed_led_i(speed_led_i), .activity_collision_led_i(activity_collision_led_i), .phy_addr_o(phy_addr_o),
    .isolate_o(isolate_o), .an_enable_o(an_enable_o), .speed100_o(speed100_o), .full_duplex_o(full_duplex_o),
    .adv_o(adv_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic finish_test();
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Advertised abilities {100 full, 100 half, 10 full, 10 half} for a mode code.
  function automatic logic [3:0] exp_adv(input logic [1:0] mode);
    case (mode)
      2'h0: return 4'h3;
      2'h1: return 4'hc;
      2'h2: return 4'h5;
      default: return 4'hf;
    endcase
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw, w, done;
    aw = 1;
    w = 1;
    done = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!done) begin
      @(posedge clk_i);
      if (aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 0;
        aw = 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 0;
        w = 0;
      end
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        done = 1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, done;
    ar = 1;
    done = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(posedge clk_i);
      if (ar && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 0;
        ar = 0;
      end
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        done = 1;
      end
    end
  endtask

  // Straps change mid-reset; only the level at the last reset edge may count.
  task automatic strap_reset(input logic [7:0] en, input logic [7:0] val);
    @(posedge clk_i);
    rst_n_i <= 0;
    res_en <= 8'hff;
    res_val <= ~val;
    repeat (5) @(posedge clk_i);
    res_en <= en;
    res_val <= val;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic check_config(input logic [7:0] s);
    check("phy_addr", phy_addr_o, s[4:0]);
    check("isolate", isolate_o, s[4:0] == 5'h00);
    check("an_enable", an_enable_o, s[7]);
    check("speed100", speed100_o, s[6]);
    check("full_duplex", full_duplex_o, s[5]);
    check("adv", adv_o, exp_adv(s[6:5]));
    axi_read(8'h0c, rd, rsp);
    check("status", rd, {16'h0000, s, 6'h00, 1'b1, s[4:0] == 5'h00});
    axi_read(8'h04, rd, rsp);
    check("bmcr", rd[13:12], {s[6], s[7]});
    check("bmcr_duplex", rd[8], s[5]);
    axi_read(8'h08, rd, rsp);
    check("anar", rd[8:5], exp_adv(s[6:5]));
  endtask

  initial begin
    void'($urandom(32'hed25_2336));
    strap_reset(8'h00, 8'h00);
    check_config(8'he1);
    for (int i = 0; i < 10; i++) begin
      st = 8'($urandom);
      st[7:5] = i[2:0];
      if (i == 0) begin
        st[4:0] = 5'h00;
      end else if (i == 1) begin
        st[4:0] = 5'h1f;
      end
      strap_reset(8'hff, st);
      check_config(st);
      @(posedge clk_i);
      res_val <= ~st;
      fn = 5'($urandom);
      col_i <= fn[0];
      rxd_i <= fn[4:1];
      link_led_i <= ~fn[2];
      speed_led_i <= fn[3];
      activity_collision_led_i <= ~fn[0];
      repeat (2) @(posedge clk_i);
      check("pad_oe", pad_oe_o, 8'hff);
      check("pad_out", pad_o, {~fn[0], fn[3], ~fn[2], fn[4:1], fn[0]});
      check("pad_level", pad_i, pad_o);
      check("addr_frozen", phy_addr_o, st[4:0]);
    end
    axi_write(8'h00, 32'h0000_0000, 4'hf, rsp);
    check("ctrl_wr_resp", rsp, RESP_OKAY);
    axi_read(8'h00, rd, rsp);
    check("ctrl_rd", rd[4:0], 5'h00);
    check("no_sw_isolate", isolate_o, st[4:0] == 5'h00);
    axi_write(8'h0c, 32'hffff_ffff, 4'hf, rsp);
    check("stat_wr_resp", rsp, RESP_OKAY);
    axi_read(8'h0c, rd, rsp);
    check("stat_ro", rd[15:8], st);
    axi_write(8'h10, 32'h0000_001f, 4'hf, rsp);
    check("unmapped_wr", rsp, RESP_SLVERR);
    axi_read(8'h14, rd, rsp);
    check("unmapped_rd", rd, 32'h0000_0000);
    check("unmapped_rresp", rsp, RESP_SLVERR);
    // Byte 0 of the mode word holds no field, so this write must leave the mode alone.
    axi_write(8'h04, 32'h0000_3100, 4'h1, rsp);
    check("bmcr_strb_skip", {an_enable_o, speed100_o, full_duplex_o}, st[7:5]);
    axi_write(8'h04, 32'h0000_1000, 4'h2, rsp);
    check("bmcr_wr", {an_enable_o, speed100_o, full_duplex_o}, 3'h4);
    axi_write(8'h08, 32'h0000_00a0, 4'hf, rsp);
    check("anar_wr", adv_o, 4'h5);
    strap_reset(8'h00, 8'h00);
    axi_read(8'h00, rd, rsp);
    check("ctrl_after_reset", rd[4:0], CTRL_ADDR_RST);
    finish_test();
  end
endmodule

`default_nettype wire
